// file: dv/video_sprite_engine_props.sv
`timescale 1ns/10ps
module video_sprite_engine_props #(
   parameter int H_VISIBLE = 160,
   parameter int H_TOTAL   = 256,
   parameter int V_VISIBLE = 200,
   parameter int V_TOTAL   = 262
) (
   input wire logic                  clk,
   input wire logic                  reset_n,
   input wire logic [15:0]           reg_addr,
   input wire logic [7:0]            reg_wdata,
   input wire logic                  reg_wr,
   input wire logic                  reg_rd,
   input wire logic [7:0]            reg_rdata,
   input wire logic                  irq,
   input wire sprite_pkg::vram_req_t vram_req,
   input wire logic [7:0]            vram_data,
   input wire logic [3:0]            bg_color,
   input wire logic [3:0]            border_color,
   input wire logic [8:0]            pos_x,
   input wire logic [8:0]            pos_y,
   input wire logic [15:0]           screen_base,
   input wire logic [15:0]           color_base,
   input wire logic [3:0]            pixel_color,
   input wire logic                  pixel_blank
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside its slot");
   property p_vram_pulse; vram_req.rd |=> !vram_req.rd; endproperty
   a_vram_pulse: assert property (p_vram_pulse)
      else $error("image fetches not two cycles apart");
   property p_vram_window; vram_req.rd |-> vram_req.addr >= 16'ha000 && vram_req.addr <= 16'hdfff;
   endproperty
   a_vram_window: assert property (p_vram_window)
      else $error("image fetch outside the window");
   property p_vram_hblank; vram_req.rd |-> pos_x >= 9'(H_VISIBLE); endproperty
   a_vram_hblank: assert property (p_vram_hblank)
      else $error("image fetch during the visible part of a line");
   // the restart edge after reset may repeat a count, so two settled edges are required
   property p_pos_step;
      $past(reset_n, 2) && pos_x != 9'(H_TOTAL - 1) |=> pos_x == $past(pos_x) + 9'h1;
   endproperty
   a_pos_step: assert property (p_pos_step)
      else $error("horizontal count skipped");
   property p_frame_wrap;
      pos_x == 9'(H_TOTAL - 1) && pos_y == 9'(V_TOTAL - 1) |=> pos_x == 9'h0 && pos_y == 9'h0;
   endproperty
   a_frame_wrap: assert property (p_frame_wrap)
      else $error("frame did not wrap");
   property p_blank_region;
      $past(reset_n, 2) |-> pixel_blank == (pos_x >= 9'(H_VISIBLE) || pos_y >= 9'(V_VISIBLE));
   endproperty
   a_blank_region: assert property (p_blank_region)
      else $error("blank flag disagrees with raster position");
   property p_irq_fall; $fell(irq) |-> $past(reg_wr); endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("interrupt dropped without a write");
   property p_base_align;
      screen_base[9:0] == 10'h000 && color_base[9:0] == 10'h000 && screen_base >= 16'ha000;
   endproperty
   a_base_align: assert property (p_base_align)
      else $error("screen or color base misaligned");

   c_fetch: cover property (vram_req.rd);
   c_irq: cover property ($rose(irq));
   c_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule

bind video_sprite_engine video_sprite_engine_props #(.H_VISIBLE(H_VISIBLE), .H_TOTAL(H_TOTAL),
   .V_VISIBLE(V_VISIBLE), .V_TOTAL(V_TOTAL)) props (.clk(clk), .reset_n(reset_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .irq(irq), .vram_req(vram_req), .vram_data(vram_data),
   .bg_color(bg_color), .border_color(border_color), .pos_x(pos_x), .pos_y(pos_y),
   .screen_base(screen_base), .color_base(color_base), .pixel_color(pixel_color),
   .pixel_blank(pixel_blank));

// file: dv/video_sprite_engine_tb.sv
`timescale 1ns/10ps
module video_sprite_engine_tb;
   localparam int HV = 16;
   localparam int VV = 8;
   logic                  clk = 1'b0;
   logic                  reset_n = 1'b0;
   logic [15:0]           reg_addr = 16'h0000;
   logic [7:0]            reg_wdata = 8'h00;
   logic                  reg_wr = 1'b0;
   logic                  reg_rd = 1'b0;
   logic [7:0]            reg_rdata;
   logic                  irq;
   sprite_pkg::vram_req_t vram_req;
   logic [7:0]            vram_data;
   logic [8:0]            pos_x;
   logic [8:0]            pos_y;
   logic [15:0]           screen_base;
   logic [15:0]           color_base;
   logic [3:0]            pixel_color;
   logic                  pixel_blank;
   int                    n_mismatch = 0;
   int                    check_count = 0;
   logic [3:0]            exp_line [0:15];
   logic [3:0]            bg_color = 4'h3;
   logic [7:0]            cfg [0:15] = '{8'h0c, 8'h15, 8'h95, 8'h10, 8'h0c, 8'h15, 8'h21, 8'h11,
                                         8'h10, 8'h15, 8'h87, 8'h10, 8'h18, 8'h14, 8'h21, 8'h10};

   always #12.5 clk = ~clk;

   video_sprite_engine #(.H_VISIBLE(HV), .H_TOTAL(84), .V_VISIBLE(VV), .V_TOTAL(12)) dut (
      .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
      .vram_req(vram_req), .vram_data(vram_data), .bg_color(bg_color), .border_color(4'he),
      .pos_x(pos_x), .pos_y(pos_y), .screen_base(screen_base), .color_base(color_base),
      .pixel_color(pixel_color), .pixel_blank(pixel_blank));
   vram_model mem_side (.clk(clk), .req(vram_req), .data(vram_data));

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(negedge clk);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
   endtask
   task automatic goto(input int x, input int y);
      int n;
      n = 0;
      @(negedge clk);
      while (!(pos_x == 9'(x) && pos_y == 9'(y)) && n < 2100) begin
         @(negedge clk);
         n++;
      end
      if (n >= 2100) begin
         n_mismatch++;
         stop_test;
      end
   endtask
   task automatic chk_line;
      goto(0, 0);
      for (int h = 0; h < HV; h++) begin
         chk("pixel_color", {12'h000, exp_line[h]}, {12'h000, pixel_color});
         @(negedge clk);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      #1000000;
      n_mismatch++;
      stop_test;
   end

   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      rd(sprite_pkg::ADDR_SHARED, 8'h00);
      for (int i = 0; i < 256; i++) wr(16'hd080 + 16'(i), 8'(i) ^ 8'ha5);
      for (int i = 0; i < 256; i++) rd(16'hd080 + 16'(i), 8'(i) ^ 8'ha5);
      rd(16'hd010, 8'h00);
      wr(sprite_pkg::ADDR_BLANK, 8'hff);
      goto(0, 2);
      rd(sprite_pkg::ADDR_BLANK, 8'h00);
      goto(0, VV + 1);
      rd(sprite_pkg::ADDR_BLANK, 8'h01);
      $display("test registers done");
      // shared image slot 0x10 and a second slot 0x11 for the overlap case
      mem_side.mem[16'h0400] = 8'h1b;
      mem_side.mem[16'h0403] = 8'h6c;
      mem_side.mem[16'h0440] = 8'h55;
      for (int i = 0; i < 32; i++) wr(16'hd080 + 16'(i), 8'h00);
      for (int i = 0; i < 32; i++) wr(16'hd0a0 + 16'(i), 8'h00);
      for (int i = 0; i < 16; i++) wr(16'hd080 + 16'(i), cfg[i]);
      wr(sprite_pkg::ADDR_SHARED, 8'h0c);
      exp_line = '{4'h1, 4'h5, 4'h9, 4'hc, 4'h3, 4'h7, 4'h8, 4'hc,
                   4'h3, 4'h3, 4'h3, 4'h3, 4'h1, 4'h2, 4'hc, 4'h3};
      goto(0, VV);
      chk_line;
      $display("test sprites done");
      wr(sprite_pkg::ADDR_SHARED, 8'h1c);
      @(posedge clk);
      bg_color <= 4'h6;
      for (int h = 0; h < HV; h++) exp_line[h] = 4'h6;
      goto(0, VV);
      chk_line;
      @(posedge clk);
      bg_color <= 4'h3;
      wr(sprite_pkg::ADDR_SHARED, 8'h0c);
      exp_line = '{4'he, 4'he, 4'he, 4'he, 4'h3, 4'h7, 4'h8, 4'hc,
                   4'h3, 4'h3, 4'h3, 4'h3, 4'he, 4'he, 4'he, 4'he};
      wr(sprite_pkg::ADDR_CONTROL, 8'h04);
      goto(0, VV);
      chk_line;
      $display("test bank and scroll done");
      wr(sprite_pkg::ADDR_BASE, 8'h30);
      wr(sprite_pkg::ADDR_COLOR_BASE, 8'h05);
      goto(0, VV);
      goto(4, 0);
      chk("screen_base", 16'hac00, screen_base);
      chk("color_base", 16'hb400, color_base);
      $display("test bases done");
      wr(sprite_pkg::ADDR_IRQ_MASK, 8'h01);
      wr(sprite_pkg::ADDR_IRQ_STATUS, 8'h03);
      chk("irq", 16'h0000, {15'h0000, irq});
      goto(4, VV);
      chk("irq", 16'h0001, {15'h0000, irq});
      rd(sprite_pkg::ADDR_IRQ_STATUS, 8'h01);
      wr(sprite_pkg::ADDR_IRQ_MASK, 8'h00);
      chk("irq", 16'h0000, {15'h0000, irq});
      wr(sprite_pkg::ADDR_IRQ_MASK, 8'h01);
      chk("irq", 16'h0001, {15'h0000, irq});
      wr(sprite_pkg::ADDR_IRQ_STATUS, 8'h01);
      chk("irq", 16'h0000, {15'h0000, irq});
      rd(sprite_pkg::ADDR_IRQ_STATUS, 8'h00);
      goto(4, 0);
      rd(sprite_pkg::ADDR_IRQ_STATUS, 8'h02);
      $display("test interrupts done");
      stop_test;
   end
endmodule

// file: dv/vram_model.sv
`timescale 1ns/10ps
module vram_model (
   input  wire logic                  clk,
   input  wire sprite_pkg::vram_req_t req,
   output logic      [7:0]            data
);
   logic [7:0] mem [0:16383];
   logic [7:0] idle_data = 8'h00;

   initial begin
      for (int i = 0; i < 16384; i++) mem[i] = 8'h00;
   end
   // the engine takes the byte at the end of its strobe cycle, so the answer is
   // combinational; between strobes the bus shows the inverse of the last byte
   always @(posedge clk) begin
      if (req.rd) begin
         idle_data <= ~mem[14'(req.addr - 16'ha000)];
      end
   end
   assign data = req.rd ? mem[14'(req.addr - 16'ha000)] : idle_data;
endmodule

// file: rtl/sprite_pkg.sv
// Operation
// [R01] sprites are 12x21, three colors plus transparent
// [R02] 63-byte image, four 2-bit pixels, msb left
// [R03] code 0 clear, 1-2 private, 3 shared
// [R04] image at window base plus pointer times 64
// [R05] four bytes per sprite: x, y, colors, pointer
// [R06] coordinates carry 12/21 pixel invisible margin
// [R07] color low nibble color 1, high color 2
// [R08] shared color from low nibble, shared register
// [R09] eight sprites shown together, independent settings
// [R10] sprites drawn over character background
// [R11] sprites may share one image slot
// [R12] whole 256-byte page holds sprite banks
// [R13] host does coarse scroll by base flip
// [R14] color memory relocatable alongside screen memory
// [R15] blanking register: 0 visible, 1 blank/border
// [R16] shared high nibble selects sprite bank
// [R17] control bit 2: fine scroll, two columns bordered
// [R18] lower-numbered sprite wins overlapping opaque pixels
// [R19] registers sampled per line, safe anytime; control bit 2 is not latched per line and switches the border at once
package sprite_pkg;
   localparam logic [15:0] ADDR_BLANK       = 16'hd000;
   localparam logic [15:0] ADDR_CONTROL     = 16'hd001;
   localparam logic [15:0] ADDR_COLOR_BASE  = 16'hd002;
   localparam logic [15:0] ADDR_BASE        = 16'hd003;
   localparam logic [15:0] ADDR_SHARED      = 16'hd006;
   localparam logic [15:0] ADDR_IRQ_STATUS  = 16'hd00c;
   localparam logic [15:0] ADDR_IRQ_MASK    = 16'hd00d;
   localparam logic [15:0] ADDR_SPRITE_BASE = 16'hd080;
   localparam logic [15:0] ADDR_SPRITE_END  = 16'hd17f;

   localparam logic [15:0] WINDOW_BASE      = 16'ha000;
   localparam int          SLOT_SHIFT       = 6;
   localparam int          SCREEN_SHIFT     = 10;

   localparam int          CTRL_HSCROLL_BIT = 2;
   localparam int          IRQ_BLANK_BIT    = 0;
   localparam int          IRQ_VISIBLE_BIT  = 1;
   localparam int          IRQ_BITS         = 2;

   localparam int          SPRITE_W         = 12;
   localparam int          SPRITE_H         = 21;
   localparam int          ROW_BYTES        = 3;
   localparam int          MARGIN_X         = 12;
   localparam int          MARGIN_Y         = 21;
   localparam int          NUM_SPRITES      = 8;
   localparam int          REGS_PER_SPRITE  = 4;
   localparam int          COLUMN_PIXELS    = 4;

   localparam logic [1:0]  FIELD_X          = 2'h0;
   localparam logic [1:0]  FIELD_Y          = 2'h1;
   localparam logic [1:0]  FIELD_COLORS     = 2'h2;
   localparam logic [1:0]  FIELD_POINTER    = 2'h3;

   localparam logic [1:0]  CODE_CLEAR       = 2'h0;
   localparam logic [1:0]  CODE_PRIVATE1    = 2'h1;
   localparam logic [1:0]  CODE_PRIVATE2    = 2'h2;

   typedef struct packed {
      logic        on;
      logic [7:0]  x;
      logic [3:0]  color1;
      logic [3:0]  color2;
      logic [23:0] pixels;
   } sprite_line_t;

   typedef struct packed {
      logic        rd;
      logic [15:0] addr;
   } vram_req_t;
endpackage

// file: rtl/video_sprite_engine.sv
`timescale 1ns/10ps
module video_sprite_engine #(
   parameter int H_VISIBLE = 160,
   parameter int H_TOTAL   = 256,
   parameter int V_VISIBLE = 200,
   parameter int V_TOTAL   = 262
) (
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire logic [15:0]          reg_addr,
   input  wire logic [7:0]           reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [7:0]           reg_rdata,
   output logic                      irq,
   output sprite_pkg::vram_req_t     vram_req,
   input  wire logic [7:0]           vram_data,
   input  wire logic [3:0]           bg_color,
   input  wire logic [3:0]           border_color,
   output logic      [8:0]           pos_x,
   output logic      [8:0]           pos_y,
   output logic      [15:0]          screen_base,
   output logic      [15:0]          color_base,
   output logic      [3:0]           pixel_color,
   output logic                      pixel_blank
);
   // the line fetch spends one setup cycle per sprite and two per image byte,
   // all inside horizontal blanking, so blanking must cover the worst line
   localparam int FETCH_CYCLES = 1 + sprite_pkg::NUM_SPRITES * (1 + 2 * sprite_pkg::ROW_BYTES);
   localparam int PAGE_BYTES   =
      int'(sprite_pkg::ADDR_SPRITE_END - sprite_pkg::ADDR_SPRITE_BASE) + 1;

   if (H_TOTAL - H_VISIBLE < FETCH_CYCLES + 1) begin : g_bad_hblank
      $error("video_sprite_engine: horizontal blanking too short for the line fetch");
   end

   if (H_TOTAL > 511 || V_TOTAL > 511) begin : g_bad_total
      $error("video_sprite_engine: raster totals exceed the position counters");
   end

   if (H_VISIBLE >= H_TOTAL || V_VISIBLE >= V_TOTAL || V_VISIBLE < 1) begin : g_bad_visible
      $error("video_sprite_engine: visible area must be non-empty and inside the frame");
   end

   if (H_VISIBLE < 2 * sprite_pkg::COLUMN_PIXELS) begin : g_bad_width
      $error("video_sprite_engine: visible width too narrow for the scroll border");
   end

   localparam logic [8:0] H_LAST  = 9'(H_TOTAL - 1);
   localparam logic [8:0] V_LAST  = 9'(V_TOTAL - 1);
   localparam logic [8:0] H_VIS   = 9'(H_VISIBLE);
   localparam logic [8:0] V_VIS   = 9'(V_VISIBLE);
   localparam logic [8:0] MX      = 9'(sprite_pkg::MARGIN_X);
   localparam logic [8:0] MY      = 9'(sprite_pkg::MARGIN_Y);
   localparam logic [8:0] SW      = 9'(sprite_pkg::SPRITE_W);
   localparam logic [8:0] SH      = 9'(sprite_pkg::SPRITE_H);
   localparam logic [8:0] COL_PIX = 9'(sprite_pkg::COLUMN_PIXELS);

   typedef enum logic [1:0] {FETCH_IDLE, FETCH_SETUP, FETCH_ISSUE, FETCH_CAPTURE} fetch_state_t;

   // register file
   logic [7:0] control_reg;
   logic [7:0] base_reg;
   logic [7:0] color_base_reg;
   logic [7:0] shared_reg;
   logic [sprite_pkg::IRQ_BITS-1:0] irq_status_reg;
   logic [sprite_pkg::IRQ_BITS-1:0] irq_mask_reg;
   logic [7:0] sprite_ram [PAGE_BYTES];

   // timing
   logic [8:0] h_reg;
   logic [8:0] v_reg;
   logic       blank_status_reg;

   // fetch
   fetch_state_t fetch_state_reg;
   logic [2:0]   fetch_idx_reg;
   logic [1:0]   fetch_byte_reg;
   logic [4:0]   fetch_row_reg;
   logic [7:0]   fetch_ptr_reg;
   logic [3:0]   shared_line_reg;
   sprite_pkg::sprite_line_t line_reg [sprite_pkg::NUM_SPRITES];

   logic       sprite_hit;
   logic [7:0] sprite_index;
   logic       blank_event;
   logic       visible_event;
   logic [8:0] next_line;

   // the whole page decodes to the sprite banks, eight banks of 32 bytes
   assign sprite_hit   = (reg_addr >= sprite_pkg::ADDR_SPRITE_BASE) &&
                         (reg_addr <= sprite_pkg::ADDR_SPRITE_END); // [R12]
   assign sprite_index = 8'(reg_addr - sprite_pkg::ADDR_SPRITE_BASE);

   // register writes; the write to the blanking register is ignored
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         control_reg    <= 8'h00;
         base_reg       <= 8'h00;
         color_base_reg <= 8'h00;
         shared_reg     <= 8'h00;
         irq_mask_reg   <= '0;
      end else if (reg_wr) begin
         case (reg_addr)
            sprite_pkg::ADDR_CONTROL:    control_reg    <= reg_wdata;
            sprite_pkg::ADDR_BASE:       base_reg       <= reg_wdata;
            sprite_pkg::ADDR_COLOR_BASE: color_base_reg <= reg_wdata; // [R14]
            sprite_pkg::ADDR_SHARED:     shared_reg     <= reg_wdata;
            sprite_pkg::ADDR_IRQ_MASK:   irq_mask_reg   <= reg_wdata[sprite_pkg::IRQ_BITS-1:0];
            default: ;
         endcase
      end
   end

   // per-sprite bank page, cleared so an unprogrammed sprite sits off screen
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            sprite_ram[i] <= 8'h00;
         end
      end else if (reg_wr && sprite_hit) begin
         sprite_ram[sprite_index] <= reg_wdata; // [R05]
      end
   end

   // set wins over a write-one clear in the same cycle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irq_status_reg <= '0;
      end else begin
         for (int b = 0; b < sprite_pkg::IRQ_BITS; b++) begin
            if ((b == sprite_pkg::IRQ_BLANK_BIT && blank_event) ||
                (b == sprite_pkg::IRQ_VISIBLE_BIT && visible_event)) begin
               irq_status_reg[b] <= 1'b1;
            end else if (reg_wr && reg_addr == sprite_pkg::ADDR_IRQ_STATUS && reg_wdata[b]) begin
               irq_status_reg[b] <= 1'b0;
            end
         end
      end
   end

   // level output: stays high until software clears or masks every pending bit
   assign irq = |(irq_status_reg & irq_mask_reg);

   // read data stands for one cycle only and then returns to zero, so a stale
   // value can never be taken for an answer
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (sprite_hit) begin
            reg_rdata <= sprite_ram[sprite_index];
         end else begin
            case (reg_addr)
               sprite_pkg::ADDR_BLANK:      reg_rdata <= {7'h00, blank_status_reg}; // [R15]
               sprite_pkg::ADDR_CONTROL:    reg_rdata <= control_reg;
               sprite_pkg::ADDR_BASE:       reg_rdata <= base_reg;
               sprite_pkg::ADDR_COLOR_BASE: reg_rdata <= color_base_reg;
               sprite_pkg::ADDR_SHARED:     reg_rdata <= shared_reg;
               sprite_pkg::ADDR_IRQ_STATUS: reg_rdata <= 8'(irq_status_reg);
               sprite_pkg::ADDR_IRQ_MASK:   reg_rdata <= 8'(irq_mask_reg);
               default:                     reg_rdata <= 8'h00;
            endcase
         end
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // raster counters
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         h_reg <= 9'h000;
         v_reg <= 9'h000;
      end else if (h_reg == H_LAST) begin
         h_reg <= 9'h000;
         v_reg <= (v_reg == V_LAST) ? 9'h000 : v_reg + 9'h001;
      end else begin
         h_reg <= h_reg + 9'h001;
      end
   end

   assign blank_event   = (h_reg == H_LAST) && (v_reg == V_VIS - 9'h001);
   assign visible_event = (h_reg == H_LAST) && (v_reg == V_LAST);
   assign next_line     = (v_reg == V_LAST) ? 9'h000 : v_reg + 9'h001;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         blank_status_reg <= 1'b1;
      end else if (blank_event) begin
         blank_status_reg <= 1'b1; // [R15]
      end else if (visible_event) begin
         blank_status_reg <= 1'b0;
      end
   end

   // screen and color bases flip together at the frame boundary, so a host
   // switching screens mid-frame never shows a mixed frame
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         screen_base <= sprite_pkg::WINDOW_BASE;
         color_base  <= sprite_pkg::WINDOW_BASE;
      end else if (visible_event) begin
         screen_base <= sprite_pkg::WINDOW_BASE +
                        ({12'h000, base_reg[7:4]} << sprite_pkg::SCREEN_SHIFT); // [R13]
         color_base  <= sprite_pkg::WINDOW_BASE +
                        ({12'h000, color_base_reg[3:0]} << sprite_pkg::SCREEN_SHIFT); // [R14]
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pos_x <= 9'h000;
         pos_y <= 9'h000;
      end else begin
         pos_x <= h_reg;
         pos_y <= v_reg;
      end
   end

   // line fetch runs in horizontal blanking for the coming line
   logic [7:0] bank_off;
   logic [7:0] cur_y;
   logic [8:0] row_dist;
   assign bank_off = {shared_reg[6:4], fetch_idx_reg, 2'b00}; // [R16]
   assign cur_y    = sprite_ram[bank_off | 8'(sprite_pkg::FIELD_Y)];
   assign row_dist = next_line + MY - {1'b0, cur_y}; // [R06]

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         fetch_state_reg <= FETCH_IDLE;
         fetch_idx_reg   <= 3'h0;
         fetch_byte_reg  <= 2'h0;
         fetch_row_reg   <= 5'h00;
         fetch_ptr_reg   <= 8'h00;
         shared_line_reg <= 4'h0;
         vram_req        <= '0;
         for (int i = 0; i < sprite_pkg::NUM_SPRITES; i++) begin
            line_reg[i] <= '0;
         end
      end else begin
         vram_req.rd <= 1'b0;
         case (fetch_state_reg)
            FETCH_IDLE: begin
               if (h_reg == H_VIS && next_line < V_VIS) begin
                  fetch_state_reg <= FETCH_SETUP;
                  fetch_idx_reg   <= 3'h0;
                  shared_line_reg <= shared_reg[3:0]; // [R08] [R19]
               end
            end
            FETCH_SETUP: begin
               // position and colors latched once per line [R19]
               line_reg[fetch_idx_reg].x      <= sprite_ram[bank_off | 8'(sprite_pkg::FIELD_X)];
               line_reg[fetch_idx_reg].color1 <=
                  sprite_ram[bank_off | 8'(sprite_pkg::FIELD_COLORS)][3:0]; // [R07]
               line_reg[fetch_idx_reg].color2 <=
                  sprite_ram[bank_off | 8'(sprite_pkg::FIELD_COLORS)][7:4]; // [R07]
               fetch_ptr_reg  <= sprite_ram[bank_off | 8'(sprite_pkg::FIELD_POINTER)]; // [R11]
               fetch_row_reg  <= row_dist[4:0];
               fetch_byte_reg <= 2'h0;
               if (row_dist < SH) begin // [R01]
                  line_reg[fetch_idx_reg].on <= 1'b1;
                  fetch_state_reg            <= FETCH_ISSUE;
               end else begin
                  line_reg[fetch_idx_reg].on <= 1'b0;
                  fetch_idx_reg              <= fetch_idx_reg + 3'h1;
                  if (fetch_idx_reg == 3'(sprite_pkg::NUM_SPRITES - 1)) begin
                     fetch_state_reg <= FETCH_IDLE;
                  end
               end
            end
            FETCH_ISSUE: begin
               vram_req.rd   <= 1'b1;
               vram_req.addr <= sprite_pkg::WINDOW_BASE +
                                ({8'h00, fetch_ptr_reg} << sprite_pkg::SLOT_SHIFT) +
                                16'(fetch_row_reg) * 16'(sprite_pkg::ROW_BYTES) +
                                16'(fetch_byte_reg); // [R04] [R02]
               fetch_state_reg <= FETCH_CAPTURE;
            end
            FETCH_CAPTURE: begin
               // the memory answers within the strobe cycle; bytes shift in msb first
               line_reg[fetch_idx_reg].pixels <=
                  {line_reg[fetch_idx_reg].pixels[15:0], vram_data}; // [R02]
               if (fetch_byte_reg == 2'(sprite_pkg::ROW_BYTES - 1)) begin
                  fetch_idx_reg <= fetch_idx_reg + 3'h1;
                  fetch_state_reg <= (fetch_idx_reg == 3'(sprite_pkg::NUM_SPRITES - 1)) ?
                                     FETCH_IDLE : FETCH_SETUP;
               end else begin
                  fetch_byte_reg  <= fetch_byte_reg + 2'h1;
                  fetch_state_reg <= FETCH_ISSUE;
               end
            end
            default: fetch_state_reg <= FETCH_IDLE;
         endcase
      end
   end

   // per-sprite pixel lookup
   logic [1:0] code [sprite_pkg::NUM_SPRITES];
   logic [8:0] h_coord;
   assign h_coord = h_reg + MX; // [R06]

   // dx wraps to a large value left of the sprite, so one compare clips both sides
   for (genvar s = 0; s < sprite_pkg::NUM_SPRITES; s++) begin : g_sprite // [R09]
      logic [8:0]  dx;
      logic [23:0] shifted;
      assign dx      = h_coord - {1'b0, line_reg[s].x};
      assign shifted = line_reg[s].pixels << {dx[3:0], 1'b0};
      assign code[s] = (line_reg[s].on && dx < SW) ? shifted[23:22] : sprite_pkg::CODE_CLEAR;
   end

   logic [3:0] mixed;
   logic       border;
   logic       hscroll;
   always_comb begin
      mixed = bg_color; // [R10]
      // walk from highest to lowest so the lowest opaque sprite is left standing
      for (int s = sprite_pkg::NUM_SPRITES - 1; s >= 0; s--) begin
         case (code[s]) // [R03] [R18]
            sprite_pkg::CODE_CLEAR:    mixed = mixed;
            sprite_pkg::CODE_PRIVATE1: mixed = line_reg[s].color1;
            sprite_pkg::CODE_PRIVATE2: mixed = line_reg[s].color2;
            default:                   mixed = shared_line_reg;
         endcase
      end
   end

   // fine scroll eats one column at each side, two columns in all
   assign hscroll = control_reg[sprite_pkg::CTRL_HSCROLL_BIT];
   assign border  = hscroll && (h_reg < COL_PIX || h_reg >= H_VIS - COL_PIX); // [R17]

   // blank and colour are registered together so they stay aligned with pos_x
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pixel_color <= 4'h0;
         pixel_blank <= 1'b1;
      end else begin
         pixel_blank <= (h_reg >= H_VIS) || (v_reg >= V_VIS);
         pixel_color <= border ? border_color : mixed;
      end
   end
endmodule
